/* File: hw/iox_cmd_decoder.sv */
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: codes 17-20 return four counts, ports 1-4, 5-8, 9-12, 13-16.
// R2: codes 21 and 22 return eight counts, ports 1-8 and 9-16.
// R3: code 23 returns sixteen counts, one per port.
// R4: codes 24-39 return one port frequency, 24 meaning port 1.
// R5: codes 40-43 return four frequencies per group of four.
// R6: codes 44 and 45 return eight frequencies, ports 1-8 and 9-16.
// R7: code 46 returns sixteen frequencies.
// R8: codes 47-62 return one port duty cycle, 47 meaning port 1.
// R9: codes 63-66 return four duty cycles per group of four.
// R10: codes 67 and 68 return eight duty cycles, ports 1-8 and 9-16.
// R11: code 69 returns sixteen duty cycles.
// R12: codes 70-85 load the supplied debounce time of ports 1-16.
// R13: code 86 sets modes of ports 16 down to 13.
// R14: code 87 sets modes of ports 12 down to 9.
// R15: code 88 sets modes of ports 8 down to 5.
// R16: code 89 sets modes of ports 4 down to 1.
// R17: codes 1-16 return one port count, code 1 meaning port 1.
// R18: host reports zero on success, adds one per failure.
// R19: module answers only on addresses 0-14; 15 is broadcast.
// R20: several values come out in ascending port order.
// R21: unknown codes are refused and change no configuration.
module iox_cmd_decoder #(
	parameter int VAL_W = 32,
	parameter int DEB_W = 16,
	parameter int MODE_W = 4,
	parameter int NUM_PORTS = iox_pkg::NUM_PORTS
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] module_bus_address_i,
	input wire logic [3:0] addr_i,
	input wire logic [6:0] cmd_i,
	input wire logic [4*MODE_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [NUM_PORTS*VAL_W-1:0] cnt_i,
	input wire logic [NUM_PORTS*VAL_W-1:0] frq_i,
	input wire logic [NUM_PORTS*VAL_W-1:0] dut_i,
	output logic [VAL_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic [3:0] rport_o,
	output logic ack_o,
	output logic nak_o,
	output logic pending_o,
	output wire logic [NUM_PORTS*DEB_W-1:0] debounce_o,
	output wire logic [NUM_PORTS*MODE_W-1:0] mode_o
);
	// ************************************************************
	// command decoding
	// ************************************************************
	function automatic iox_pkg::iox_dec_t dec_family(
		input logic [6:0] ofs,
		input iox_pkg::iox_kind_t k
	);
		iox_pkg::iox_dec_t d;
		d.kind = k;
		d.first = 4'h0;
		d.num = iox_pkg::N_ONE;
		if (ofs < iox_pkg::FAM_GRP4_OFS) begin
			d.first = ofs[3:0]; // see R4
		end else if (ofs < iox_pkg::FAM_GRP8_OFS) begin
			d.first = {ofs[1:0], 2'b00}; // see R5
			d.num = iox_pkg::N_FOUR;
		end else if (ofs < iox_pkg::FAM_ALL_OFS) begin
			d.first = {ofs[0], 3'b000}; // see R6
			d.num = iox_pkg::N_EIGHT;
		end else begin
			d.num = iox_pkg::N_ALL; // see R7
		end
		return d;
	endfunction

	function automatic iox_pkg::iox_dec_t dec_cmd(input logic [6:0] code);
		iox_pkg::iox_dec_t d;
		logic [6:0] ofs;
		d.kind = iox_pkg::IOX_K_BAD;
		d.first = 4'h0;
		d.num = iox_pkg::N_ONE;
		ofs = 7'h00;
		if (code < iox_pkg::CNT_BASE) begin
			d.kind = iox_pkg::IOX_K_BAD; // see R21
		end else if (code < iox_pkg::FRQ_BASE) begin
			ofs = code - iox_pkg::CNT_BASE;
			d = dec_family(ofs, iox_pkg::IOX_K_CNT); // see R17
		end else if (code < iox_pkg::DUT_BASE) begin
			ofs = code - iox_pkg::FRQ_BASE;
			d = dec_family(ofs, iox_pkg::IOX_K_FRQ); // see R4
		end else if (code < iox_pkg::DEB_FIRST) begin
			ofs = code - iox_pkg::DUT_BASE;
			d = dec_family(ofs, iox_pkg::IOX_K_DUT); // see R8
		end else if (code <= iox_pkg::DEB_LAST) begin
			ofs = code - iox_pkg::DEB_FIRST;
			d.kind = iox_pkg::IOX_K_DEB; // see R12
			d.first = ofs[3:0];
		end else if (code <= iox_pkg::MODE_LAST) begin
			// highest group comes first in code order
			ofs = iox_pkg::MODE_LAST - code;
			d.kind = iox_pkg::IOX_K_MODE; // see R13 R14 R15 R16
			d.first = {ofs[1:0], 2'b00};
		end
		return d;
	endfunction

	// ************************************************************
	// own address, caught after reset release
	// ************************************************************
	logic [3:0] own_addr;
	logic addr_taken;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			own_addr <= iox_pkg::ADDR_RST;
			addr_taken <= 1'b0;
		end else if (!addr_taken) begin
			own_addr <= module_bus_address_i;
			addr_taken <= 1'b1;
		end
	end

	iox_pkg::iox_dec_t dec;
	logic hit;

	always_comb begin
		dec = dec_cmd(cmd_i);
		// a module never owns the broadcast address
		hit = wr_i && addr_taken && addr_i == own_addr
			&& addr_i != iox_pkg::BROADCAST_ADDR; // see R19
	end

	// ************************************************************
	// value stream
	// ************************************************************
	iox_pkg::iox_state_t state;
	iox_pkg::iox_kind_t kind;
	logic [3:0] cur_port;
	logic [4:0] remaining;
	logic is_read;

	always_comb begin
		is_read = dec.kind == iox_pkg::IOX_K_CNT
			|| dec.kind == iox_pkg::IOX_K_FRQ
			|| dec.kind == iox_pkg::IOX_K_DUT;
	end

	// a new read command drops whatever was still unread
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= iox_pkg::IOX_IDLE;
			kind <= iox_pkg::IOX_K_NONE;
			cur_port <= 4'h0;
			remaining <= 5'h00;
			pending_o <= 1'b0;
		end else if (hit && is_read) begin
			state <= iox_pkg::IOX_SEND; // see R1 R2 R3 R9 R10 R11
			kind <= dec.kind;
			cur_port <= dec.first;
			remaining <= dec.num;
			pending_o <= 1'b1;
		end else if (rd_i && state == iox_pkg::IOX_SEND) begin
			cur_port <= cur_port + 4'h1; // see R20
			remaining <= remaining - 5'h01;
			if (remaining == iox_pkg::N_ONE) begin
				state <= iox_pkg::IOX_IDLE;
				pending_o <= 1'b0;
			end
		end
	end

	logic [VAL_W-1:0] sel_val;

	always_comb begin
		case (kind)
			iox_pkg::IOX_K_CNT: sel_val = cnt_i[int'(cur_port)*VAL_W +: VAL_W];
			iox_pkg::IOX_K_FRQ: sel_val = frq_i[int'(cur_port)*VAL_W +: VAL_W];
			iox_pkg::IOX_K_DUT: sel_val = dut_i[int'(cur_port)*VAL_W +: VAL_W];
			default: sel_val = '0;
		endcase
	end

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
			rvalid_o <= 1'b0;
			rport_o <= 4'h0;
		end else if (rd_i && state == iox_pkg::IOX_SEND) begin
			rdata_o <= sel_val; // see R20
			rvalid_o <= 1'b1;
			rport_o <= cur_port;
		end else begin
			rdata_o <= '0;
			rvalid_o <= 1'b0;
		end
	end

	// ************************************************************
	// command answer
	// ************************************************************
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			nak_o <= 1'b0;
		end else begin
			ack_o <= hit && dec.kind != iox_pkg::IOX_K_BAD;
			nak_o <= hit && dec.kind == iox_pkg::IOX_K_BAD; // see R21
		end
	end

	iox_port_bank #(
		.NUM_PORTS(NUM_PORTS),
		.DEB_W(DEB_W),
		.MODE_W(MODE_W)
	) u_bank (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.deb_we_i(hit && dec.kind == iox_pkg::IOX_K_DEB), // see R12
		.deb_sel_i(dec.first),
		.deb_val_i(DEB_W'(wdata_i)),
		.mode_we_i(hit && dec.kind == iox_pkg::IOX_K_MODE), // see R16
		.mode_grp_i(dec.first[3:2]),
		.mode_val_i(wdata_i),
		.debounce_o(debounce_o),
		.mode_o(mode_o)
	);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_load(lo, hi, k, n);
		hit && cmd_i >= lo && cmd_i <= hi |=>
			state == iox_pkg::IOX_SEND && kind == k && remaining == n;
	endproperty

	a_count_single: assert property ( // see R17
		hit && cmd_i >= 7'd1 && cmd_i <= 7'd16 |=>
			remaining == 5'd1 && cur_port == 4'($past(cmd_i) - 7'd1)
			&& kind == iox_pkg::IOX_K_CNT)
		else $error("single count command misdecoded");
	a_count_four: assert property ( // see R1
		p_load(7'd17, 7'd20, iox_pkg::IOX_K_CNT, 5'd4))
		else $error("four count command misdecoded");
	a_count_eight: assert property ( // see R2
		hit && (cmd_i == 7'd21 || cmd_i == 7'd22) |=> remaining == 5'd8
			&& cur_port == ($past(cmd_i[0]) ? 4'h0 : 4'h8))
		else $error("eight count command misdecoded");
	a_count_all: assert property ( // see R3
		hit && cmd_i == 7'd23 |=> remaining == 5'd16 && cur_port == 4'h0)
		else $error("all count command misdecoded");
	a_freq_single: assert property ( // see R4
		hit && cmd_i >= 7'd24 && cmd_i <= 7'd39 |=>
			remaining == 5'd1 && cur_port == 4'($past(cmd_i) - 7'd24)
			&& kind == iox_pkg::IOX_K_FRQ)
		else $error("single frequency command misdecoded");
	a_freq_four: assert property ( // see R5
		p_load(7'd40, 7'd43, iox_pkg::IOX_K_FRQ, 5'd4))
		else $error("four frequency command misdecoded");
	a_freq_eight: assert property ( // see R6
		p_load(7'd44, 7'd45, iox_pkg::IOX_K_FRQ, 5'd8))
		else $error("eight frequency command misdecoded");
	a_freq_all: assert property ( // see R7
		p_load(7'd46, 7'd46, iox_pkg::IOX_K_FRQ, 5'd16))
		else $error("all frequency command misdecoded");
	a_duty_single: assert property ( // see R8
		hit && cmd_i >= 7'd47 && cmd_i <= 7'd62 |=>
			remaining == 5'd1 && cur_port == 4'($past(cmd_i) - 7'd47)
			&& kind == iox_pkg::IOX_K_DUT)
		else $error("single duty command misdecoded");
	a_duty_four: assert property ( // see R9
		p_load(7'd63, 7'd66, iox_pkg::IOX_K_DUT, 5'd4))
		else $error("four duty command misdecoded");
	a_duty_eight: assert property ( // see R10
		p_load(7'd67, 7'd68, iox_pkg::IOX_K_DUT, 5'd8))
		else $error("eight duty command misdecoded");
	a_duty_all: assert property ( // see R11
		p_load(7'd69, 7'd69, iox_pkg::IOX_K_DUT, 5'd16))
		else $error("all duty command misdecoded");

	sequence s_pop;
		rd_i && state == iox_pkg::IOX_SEND;
	endsequence
	sequence s_delivered;
		rvalid_o && rdata_o == $past(sel_val) && rport_o == $past(cur_port);
	endsequence
	a_ascending_order: assert property ( // see R20
		s_pop |=> s_delivered ##0 cur_port == $past(cur_port) + 4'h1)
		else $error("values out of port order");
	a_bad_refused: assert property ( // see R21
		hit && dec.kind == iox_pkg::IOX_K_BAD |=> nak_o && !ack_o
			&& remaining == $past(remaining) && $stable(debounce_o))
		else $error("unknown code not refused");
	a_broadcast_ignored: assert property ( // see R19
		wr_i && addr_i == iox_pkg::BROADCAST_ADDR |=> !ack_o && !nak_o)
		else $error("answered on broadcast address");
endmodule // iox_cmd_decoder
`default_nettype wire

/* File: inc/iox_pkg.sv */
// ************************************************************
// command codes and constants
// ************************************************************
package iox_pkg;
	localparam int NUM_PORTS = 16;
	localparam int GRP_PORTS = 4;
	// first code of each measurement family
	localparam logic [6:0] CNT_BASE = 7'h01;
	localparam logic [6:0] FRQ_BASE = 7'h18;
	localparam logic [6:0] DUT_BASE = 7'h2f;
	// setting commands
	localparam logic [6:0] DEB_FIRST = 7'h46;
	localparam logic [6:0] DEB_LAST = 7'h55;
	localparam logic [6:0] MODE_FIRST = 7'h56;
	localparam logic [6:0] MODE_LAST = 7'h59;
	// offsets inside one family
	localparam logic [6:0] FAM_GRP4_OFS = 7'h10;
	localparam logic [6:0] FAM_GRP8_OFS = 7'h14;
	localparam logic [6:0] FAM_ALL_OFS = 7'h16;
	// values returned per command
	localparam logic [4:0] N_ONE = 5'h01;
	localparam logic [4:0] N_FOUR = 5'h04;
	localparam logic [4:0] N_EIGHT = 5'h08;
	localparam logic [4:0] N_ALL = 5'h10;
	localparam logic [3:0] BROADCAST_ADDR = 4'hf;
	localparam logic [3:0] ADDR_RST = 4'h0;
	localparam logic [15:0] DEB_RST = 16'h0000;
	localparam logic [3:0] MODE_RST = 4'h0;
	typedef enum logic [2:0] {
		IOX_K_NONE, IOX_K_CNT, IOX_K_FRQ, IOX_K_DUT,
		IOX_K_DEB, IOX_K_MODE, IOX_K_BAD
	} iox_kind_t;
	typedef struct packed {
		iox_kind_t kind;
		logic [3:0] first;
		logic [4:0] num;
	} iox_dec_t;
	typedef enum logic {IOX_IDLE, IOX_SEND} iox_state_t;
endpackage

/* File: hw/iox_port_bank.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// per-port debounce and mode storage
// ************************************************************
module iox_port_bank #(
	parameter int NUM_PORTS = 16,
	parameter int DEB_W = 16,
	parameter int MODE_W = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic deb_we_i,
	input wire logic [3:0] deb_sel_i,
	input wire logic [DEB_W-1:0] deb_val_i,
	input wire logic mode_we_i,
	input wire logic [1:0] mode_grp_i,
	input wire logic [4*MODE_W-1:0] mode_val_i,
	output wire logic [NUM_PORTS*DEB_W-1:0] debounce_o,
	output wire logic [NUM_PORTS*MODE_W-1:0] mode_o
);
	logic [DEB_W-1:0] deb_q [NUM_PORTS];
	logic [MODE_W-1:0] mode_q [NUM_PORTS];

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				deb_q[p] <= DEB_W'(iox_pkg::DEB_RST);
			end else if (deb_we_i && deb_sel_i == 4'(p)) begin
				deb_q[p] <= deb_val_i; // see R12
			end
		end
		// one group of four moves together, lowest port in low bits
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				mode_q[p] <= MODE_W'(iox_pkg::MODE_RST);
			end else if (mode_we_i && mode_grp_i == 2'(p / 4)) begin
				mode_q[p] <= mode_val_i[(p % 4)*MODE_W +: MODE_W]; // see R13
			end
		end
		assign debounce_o[p*DEB_W +: DEB_W] = deb_q[p];
		assign mode_o[p*MODE_W +: MODE_W] = mode_q[p];
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_debounce_load: assert property ( // see R12
		deb_we_i |=> debounce_o[int'($past(deb_sel_i))*DEB_W +: DEB_W]
			== $past(deb_val_i))
		else $error("debounce value not loaded");
	a_mode_group_load: assert property ( // see R13 R14 R15 R16
		mode_we_i |=>
			mode_o[int'($past(mode_grp_i))*4*MODE_W +: 4*MODE_W]
			== $past(mode_val_i))
		else $error("mode group not loaded");
	a_mode_hold_idle: assert property ( // see R21
		!mode_we_i |=> $stable(mode_o))
		else $error("mode changed without a command");
endmodule // iox_port_bank
`default_nettype wire

/* File: test/iox_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// host side of the command bus
// ************************************************************
module iox_host_model (
	input wire logic ref_clk_i,
	input wire logic ack_i,
	input wire logic nak_i,
	input wire logic rvalid_i,
	input wire logic [31:0] rdata_i,
	input wire logic [3:0] rport_i,
	input wire logic pending_i,
	output logic [3:0] addr_o,
	output logic [6:0] cmd_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	logic got_ack;
	logic got_nak;
	logic got_valid;
	logic got_pend;
	logic [31:0] got_data;
	logic [3:0] got_port;
	int status;
	initial begin
		status = 0;
		addr_o = 4'hf;
		cmd_o = 7'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// released lines show the inverse so stale values never pass
	task automatic send(input logic [3:0] a, input logic [6:0] c,
		input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_o <= a;
		cmd_o <= c;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge ref_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		cmd_o <= ~c;
		wdata_o <= ~d;
		#1;
		got_ack = ack_i;
		got_nak = nak_i;
		if (got_nak === 1'b1) begin
			status = status + 1;
		end else if (got_ack === 1'b1) begin
			status = 0;
		end
	endtask
	task automatic rd_one();
		@(posedge ref_clk_i);
		rd_o <= 1'b1;
		@(posedge ref_clk_i);
		rd_o <= 1'b0;
		#1;
		got_valid = rvalid_i;
		got_data = rdata_i;
		got_port = rport_i;
		got_pend = pending_i;
	endtask
endmodule // iox_host_model
`default_nettype wire

/* File: test/iox_cmd_decoder_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); \
	end \
end
// ************************************************************
// self-checking bench
// ************************************************************
module iox_cmd_decoder_tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] own;
	logic [3:0] addr;
	logic [6:0] cmd;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [511:0] cnt_v;
	logic [511:0] frq_v;
	logic [511:0] dut_v;
	logic [31:0] rdata;
	logic rvalid;
	logic [3:0] rport;
	logic ack;
	logic nak;
	logic pending;
	logic [255:0] deb_w;
	logic [63:0] mode_w;
	logic [255:0] deb_old;
	logic [63:0] mode_old;
	logic [15:0] d;
	logic [6:0] bad [3] = '{7'h00, 7'h5a, 7'h7f};
	int seed;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	int code;
	int k;
	int o;
	int f;
	always #5 ref_clk_i = ~ref_clk_i;
	iox_cmd_decoder DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.module_bus_address_i(own), .addr_i(addr), .cmd_i(cmd),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .cnt_i(cnt_v),
		.frq_i(frq_v), .dut_i(dut_v), .rdata_o(rdata),
		.rvalid_o(rvalid), .rport_o(rport), .ack_o(ack), .nak_o(nak),
		.pending_o(pending), .debounce_o(deb_w), .mode_o(mode_w));
	iox_host_model HOST (.ref_clk_i(ref_clk_i), .ack_i(ack),
		.nak_i(nak), .rvalid_i(rvalid), .rdata_i(rdata),
		.rport_i(rport), .pending_i(pending), .addr_o(addr),
		.cmd_o(cmd), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	// offset inside a family of 23 codes
	function automatic int exp_first(int ofs);
		if (ofs < 16) return ofs;
		if (ofs < 20) return (ofs - 16) * 4;
		if (ofs < 22) return (ofs - 20) * 8;
		return 0;
	endfunction
	function automatic int exp_num(int ofs);
		if (ofs < 16) return 1;
		if (ofs < 20) return 4;
		if (ofs < 22) return 8;
		return 16;
	endfunction
	function automatic logic [31:0] meas(int fam, int p);
		if (fam == 0) return cnt_v[p*32 +: 32];
		if (fam == 1) return frq_v[p*32 +: 32];
		return dut_v[p*32 +: 32];
	endfunction
	task automatic fill();
		@(posedge ref_clk_i);
		for (int p = 0; p < 16; p++) begin
			cnt_v[p*32 +: 32] <= $random(seed);
			frq_v[p*32 +: 32] <= $random(seed);
			dut_v[p*32 +: 32] <= $random(seed);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// tests need about 700 cycles, so a hang stops well short of forever
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_total++;
			results();
		end
	end
	initial begin
		seed = 32'h3e65706c;
		own = 4'(($random(seed) & 32'h7fffffff) % 15);
		cnt_v = '0;
		frq_v = '0;
		dut_v = '0;
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		for (code = 1; code <= 69; code++) begin
			fill();
			HOST.send(own, 7'(code), 16'h0000);
			`CHK(HOST.got_ack, 1'b1)
			`CHK(pending, 1'b1)
			f = (code - 1) / 23;
			o = (code - 1) % 23;
			for (k = 0; k < exp_num(o); k++) begin
				HOST.rd_one();
				`CHK(HOST.got_valid, 1'b1)
				`CHK(HOST.got_port, 4'(exp_first(o) + k))
				`CHK(HOST.got_data, meas(f, exp_first(o) + k))
			end
			`CHK(HOST.got_pend, 1'b0)
		end
		// a new read command drops the rest of an unfinished stream
		HOST.send(own, 7'd23, 16'h0000);
		HOST.rd_one();
		HOST.send(own, 7'd17, 16'h0000);
		for (k = 0; k < 4; k++) begin
			HOST.rd_one();
			`CHK(HOST.got_port, 4'(k))
			`CHK(HOST.got_data, meas(0, k))
		end
		`CHK(HOST.got_pend, 1'b0)
		$display("test stream restart done");
		HOST.rd_one();
		`CHK({HOST.got_valid, HOST.got_data}, 33'h0)
		$display("test read codes done");
		for (code = 70; code <= 89; code++) begin
			d = 16'($random(seed));
			HOST.send(own, 7'(code), d);
			`CHK(HOST.got_ack, 1'b1)
			if (code <= 85) begin
				`CHK(deb_w[(code-70)*16 +: 16], d)
			end else begin
				`CHK(mode_w[(89-code)*16 +: 16], d)
			end
		end
		$display("test setting codes done");
		for (k = 0; k < 3; k++) begin
			deb_old = deb_w;
			mode_old = mode_w;
			HOST.send(own, bad[k], 16'($random(seed)));
			`CHK({HOST.got_ack, HOST.got_nak}, 2'b01)
			`CHK({deb_w, mode_w}, {deb_old, mode_old})
		end
		`CHK(HOST.status, 3)
		HOST.send(4'hf, 7'h46, 16'h1234);
		`CHK({HOST.got_ack, HOST.got_nak}, 2'b00)
		HOST.send(own ^ 4'h1, 7'h46, 16'h4321);
		`CHK({HOST.got_ack, HOST.got_nak}, 2'b00)
		`CHK({deb_w, mode_w}, {deb_old, mode_old})
		$display("test refusals done");
		results();
	end
endmodule // iox_cmd_decoder_tb
`default_nettype wire
